// file: bench/test_occ_regs.sv
// testbench for the oscillator control register block
// assumes occ_pkg and occ_regs are compiled first; the bench drives every input
`timescale 1ns/1ps

module test_occ_regs;
    import occ_pkg::*;

    // ********************************
    // signals
    // ********************************
    localparam logic [7:0] A_OSC = OCC_OSC_CTRL_OFF;
    localparam logic [7:0] A_DIV = OCC_CLK_DIV_OFF;
    localparam logic [7:0] A_FBD = OCC_PLL_FBD_OFF;
    localparam logic [7:0] A_TUN = OCC_TUNE_OFF;
    logic mclk, reset, por_reset, pll_locked, pll_timer_done, pll_enabled;
    logic [2:0] init_source_cfg, current_source_sel, requested_source_sel;
    logic [1:0] switching_mode_cfg;
    logic clock_fail_event, switch_done, interrupt_event, psel, penable, pwrite;
    logic [7:0] paddr, doze_divide;
    logic [31:0] pwdata, prdata, w;
    logic pready, pslverr, switch_start, pin_select_lock, secondary_osc_enable;
    logic fail_safe_monitor;
    logic [8:0] fast_rc_divide;
    logic [3:0] pll_output_divide;
    logic [5:0] pll_input_divide, fast_rc_trim;
    logic [9:0] pll_multiplier;
    logic [32:0] exp_q[$];
    logic [32:0] exp_e;
    int err_total, cmp_count, pst;
    integer seed;

    occ_regs occ_regs_i (
        .mclk(mclk), .reset(reset), .por_reset(por_reset),
        .init_source_cfg(init_source_cfg), .switching_mode_cfg(switching_mode_cfg),
        .pll_locked(pll_locked), .pll_timer_done(pll_timer_done), .pll_enabled(pll_enabled),
        .clock_fail_event(clock_fail_event), .switch_done(switch_done),
        .interrupt_event(interrupt_event), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .current_source_sel(current_source_sel),
        .requested_source_sel(requested_source_sel), .switch_start(switch_start),
        .pin_select_lock(pin_select_lock), .secondary_osc_enable(secondary_osc_enable),
        .fail_safe_monitor(fail_safe_monitor), .doze_divide(doze_divide),
        .fast_rc_divide(fast_rc_divide), .pll_output_divide(pll_output_divide),
        .pll_input_divide(pll_input_divide), .pll_multiplier(pll_multiplier),
        .fast_rc_trim(fast_rc_trim)
    );

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    // ********************************
    // tasks
    // ********************************
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t port got %h exp %h", $time, got, exp);
        end
    endtask

    // apb: setup, access held until pready is sampled high, then release
    task automatic xfer(input logic [7:0] a, input logic wr_en, input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= wr_en;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n <= 16) begin
            n++;
            @(posedge mclk);
        end
        if (pready !== 1'b1) begin
            err_total++;
            $display("ERROR t=%0t no pready", $time);
            tally_and_finish();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    // expected value is {pslverr, prdata}
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask

    task automatic unlk;
        wr(OCC_UNLOCK_OFF, {16'h0, OCC_KEY1});
        wr(OCC_UNLOCK_OFF, {16'h0, OCC_KEY2});
    endtask

    // ********************************
    // read monitor
    // ********************************
    always @(posedge mclk) begin
        if ((psel & penable & pready & ~pwrite) === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("ERROR t=%0t read without expectation", $time);
            end else begin
                exp_e = exp_q.pop_front();
                cmp_count++;
                if ({pslverr, prdata} !== exp_e) begin
                    err_total++;
                    $display("ERROR t=%0t read got %h exp %h", $time, {pslverr, prdata}, exp_e);
                end
            end
        end
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        seed = 32'haeb3;
        err_total = 0;
        cmp_count = 0;
        reset = 1'b1;
        por_reset = 1'b1;
        init_source_cfg = 3'h5;
        switching_mode_cfg = 2'h0;
        {pll_locked, pll_timer_done, pll_enabled} = 3'h0;
        {clock_fail_event, switch_done, interrupt_event} = 3'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        tick(5);
        reset <= 1'b0;
        por_reset <= 1'b0;
        tick(2);
        rd(A_OSC, 33'h5500);
        chk(32'(current_source_sel), 32'h5);
        rd(A_DIV, 33'h3040);
        rd(A_FBD, 33'h30);
        rd(A_TUN, 33'h0);
        chk(32'(pll_multiplier), 32'd50);
        chk(32'(pll_output_divide), 32'd4);
        for (int i = 0; i < 8; i++) begin
            pll_enabled <= i[2];
            pll_locked <= i[1];
            pll_timer_done <= i[0];
            tick(2);
            rd(A_OSC, (i > 4) ? 33'h5520 : 33'h5500);
        end
        pll_enabled <= 1'b0;
        wr(A_OSC, 32'h743);
        rd(A_OSC, 33'h5500);
        unlk();
        rd(OCC_UNLOCK_OFF, 33'h1);
        wr(A_TUN, 32'h0);
        wr(A_OSC, 32'h743);
        rd(A_OSC, 33'h5500);
        unlk();
        wr(A_OSC, 32'hffff_ff7f);
        rd(A_OSC, 33'h5743);
        chk(32'({switch_start, pin_select_lock, secondary_osc_enable}), 32'h7);
        chk(32'(requested_source_sel), 32'h7);
        switch_done <= 1'b1;
        tick(1);
        switch_done <= 1'b0;
        rd(A_OSC, 33'h7742);
        chk(32'({current_source_sel, switch_start}), 32'he);
        clock_fail_event <= 1'b1;
        tick(1);
        clock_fail_event <= 1'b0;
        rd(A_OSC, 33'h774a);
        chk(32'(fail_safe_monitor), 32'h1);
        unlk();
        wr(A_OSC, 32'h742);
        rd(A_OSC, 33'h7742);
        switching_mode_cfg <= 2'h2;
        unlk();
        wr(A_OSC, 32'h343);
        rd(A_OSC, 33'h7342);
        chk(32'({fail_safe_monitor, switch_start}), 32'h0);
        switching_mode_cfg <= 2'h1;
        clock_fail_event <= 1'b1;
        tick(1);
        clock_fail_event <= 1'b0;
        rd(A_OSC, 33'h7342);
        unlk();
        wr(A_OSC, 32'h143);
        rd(A_OSC, 33'h7143);
        switch_done <= 1'b1;
        tick(1);
        switch_done <= 1'b0;
        rd(A_OSC, 33'h1142);
        unlk();
        wr(A_OSC, 32'h1c2);
        unlk();
        wr(A_OSC, 32'h042);
        rd(A_OSC, 33'h10c2);
        unlk();
        wr(A_OSC, 32'h0c3);
        rd(A_OSC, 33'h10c2);
        for (int i = 0; i < 8; i++) begin
            pst = (i % 3 == 0) ? 0 : ((i % 3 == 1) ? 1 : 3);
            w = {16'h0, 1'b0, 3'(i), 1'b1, 3'(i), 2'(pst), 1'b1, 3'(i), 2'h3};
            wr(A_DIV, w);
            rd(A_DIV, {1'b0, w & 32'hffdf});
            chk(32'(doze_divide), 32'd1 << i);
            chk(32'(fast_rc_divide), (i == 7) ? 32'd256 : 32'd1 << i);
            chk(32'(pll_output_divide), 32'd2 << (pst == 3 ? 2 : pst));
            chk(32'(pll_input_divide), 32'(i * 4 + 5));
        end
        wr(A_DIV, 32'h7fbf);
        rd(A_DIV, 33'h7f5f);
        wr(A_DIV, 32'hd840);
        interrupt_event <= 1'b1;
        tick(1);
        interrupt_event <= 1'b0;
        rd(A_DIV, 33'hd040);
        chk(32'(doze_divide), 32'd1);
        wr(A_DIV, 32'h5840);
        interrupt_event <= 1'b1;
        tick(1);
        interrupt_event <= 1'b0;
        rd(A_DIV, 33'h5840);
        chk(32'(doze_divide), 32'd32);
        wr(A_FBD, 32'hffff_ffff);
        rd(A_FBD, 33'h1ff);
        chk(32'(pll_multiplier), 32'd513);
        for (int i = 0; i < 6; i++) begin
            w = $random(seed);
            wr(A_TUN, w);
            rd(A_TUN, {1'b0, w & 32'h3f});
            chk(32'(fast_rc_trim), {26'h0, w[5:0]});
        end
        wr(A_FBD, 32'h0);
        rd(8'h20, 33'h1_0000_0000);
        reset <= 1'b1;
        tick(2);
        chk(32'(pll_multiplier), 32'd50);
        reset <= 1'b0;
        tick(2);
        chk(32'(pll_multiplier), 32'd2);
        rd(A_OSC, 33'h10c2);
        init_source_cfg <= 3'h2;
        por_reset <= 1'b1;
        tick(2);
        por_reset <= 1'b0;
        tick(2);
        rd(A_OSC, 33'h2200);
        rd(A_DIV, 33'h3040);
        tally_and_finish();
    end
endmodule

// file: hw/occ_pkg.sv
// oscillator control register block: shared constants
// assumes a 32-bit apb slave with one register per aligned word
package occ_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OCC_OSC_CTRL_OFF = 8'h00;
    localparam logic [7:0] OCC_CLK_DIV_OFF = 8'h04;
    localparam logic [7:0] OCC_PLL_FBD_OFF = 8'h08;
    localparam logic [7:0] OCC_TUNE_OFF = 8'h0c;
    localparam logic [7:0] OCC_UNLOCK_OFF = 8'h10;

    // ************************************************************
    // unlock keys, written in order to the unlock register
    // ************************************************************
    localparam logic [15:0] OCC_KEY1 = 16'h0046;
    localparam logic [15:0] OCC_KEY2 = 16'h0057;

    // ************************************************************
    // oscillator_control field positions
    // ************************************************************
    localparam int OCC_CUR_LSB = 12;
    localparam int OCC_REQ_LSB = 8;
    localparam int OCC_SRCLK_BIT = 7;
    localparam int OCC_PSLK_BIT = 6;
    localparam int OCC_PLLLK_BIT = 5;
    localparam int OCC_CF_BIT = 3;
    localparam int OCC_SOSC_BIT = 1;
    localparam int OCC_SWREQ_BIT = 0;

    // ************************************************************
    // clock_divisor field positions and register reset values
    // ************************************************************
    localparam int OCC_ROI_BIT = 15;
    localparam int OCC_DOZE_LSB = 12;
    localparam int OCC_DOZE_ENABLE_BIT = 11;
    localparam int OCC_FRCDV_LSB = 8;
    localparam int OCC_POST_LSB = 6;
    localparam logic [2:0] OCC_DOZE_RST = 3'h3;
    localparam logic [2:0] OCC_FRCDV_RST = 3'h0;
    localparam logic [1:0] OCC_POST_RST = 2'h1;
    localparam logic [4:0] OCC_PRE_RST = 5'h00;
    localparam logic [8:0] OCC_FBD_RST = 9'h030;
    localparam logic [5:0] OCC_TRIM_RST = 6'h00;

    // ************************************************************
    // switching mode encodings, reserved post code, source codes and unlock states
    // ************************************************************
    localparam logic [1:0] OCC_SWM_ALL = 2'h0;
    localparam logic [1:0] OCC_SWM_NOMON = 2'h1;
    localparam logic [1:0] OCC_POST_RSVD = 2'h2;

    typedef enum logic [2:0] {
        OCC_SRC_FRC = 3'b000,
        OCC_SRC_FRC_PLL = 3'b001,
        OCC_SRC_PRI = 3'b010,
        OCC_SRC_PRI_PLL = 3'b011,
        OCC_SRC_SEC = 3'b100,
        OCC_SRC_LOW_POWER_RC_OSC = 3'b101,
        OCC_SRC_FRC16 = 3'b110,
        OCC_SRC_FRCN = 3'b111
    } occ_src_t;

    typedef enum logic [1:0] {
        OCC_UL_IDLE = 2'b00,
        OCC_UL_KEY1 = 2'b01,
        OCC_UL_OPEN = 2'b10
    } occ_ul_t;

endpackage

// file: hw/occ_regs.sv
// oscillator control register block: apb slave plus control outputs
// assumes synchronous inputs on mclk, por_reset as power-on reset only
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module occ_regs
    import occ_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic por_reset,
    input wire logic [2:0] init_source_cfg,
    input wire logic [1:0] switching_mode_cfg,
    input wire logic pll_locked,
    input wire logic pll_timer_done,
    input wire logic pll_enabled,
    input wire logic clock_fail_event,
    input wire logic switch_done,
    input wire logic interrupt_event,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] current_source_sel,
    output logic [2:0] requested_source_sel,
    output logic switch_start,
    output logic pin_select_lock,
    output logic secondary_osc_enable,
    output logic fail_safe_monitor,
    output logic [7:0] doze_divide,
    output logic [8:0] fast_rc_divide,
    output logic [3:0] pll_output_divide,
    output logic [5:0] pll_input_divide,
    output logic [9:0] pll_multiplier,
    output logic [5:0] fast_rc_trim
);
    import occ_pkg::*;

    // ************************************************************
    // register state
    // ************************************************************
    logic [2:0] cur_q;
    logic [2:0] req_q;
    logic src_lock_q;
    logic pslk_q;
    logic cf_q;
    logic sosc_q;
    logic swreq_q;
    logic roi_q;
    logic [2:0] doze_q;
    logic doze_enable_q;
    logic [2:0] frcdv_q;
    logic [1:0] post_q;
    logic [4:0] pre_q;
    logic [8:0] fbd_q;
    logic [5:0] trim_q;
    logic lock_q;
    occ_ul_t ul_q;
    logic init_done_q;

    logic wr_acc;
    logic wr_osc;
    logic sw_allowed;
    logic [15:0] osc_rd;
    logic [31:0] rd_d;
    logic unmapped;

    assign wr_acc = psel && penable && pready && pwrite;
    // oscillator control writes go through only while unlocked
    assign wr_osc = wr_acc && paddr == OCC_OSC_CTRL_OFF && ul_q == OCC_UL_OPEN;
    // switching allowed by mode and, in mode 01, by the lock bit
    assign sw_allowed = !switching_mode_cfg[1] &&
        !(switching_mode_cfg == OCC_SWM_NOMON && src_lock_q);
    assign unmapped = !(paddr == OCC_OSC_CTRL_OFF || paddr == OCC_CLK_DIV_OFF ||
        paddr == OCC_PLL_FBD_OFF || paddr == OCC_TUNE_OFF || paddr == OCC_UNLOCK_OFF);

    // ************************************************************
    // unlock sequence
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (por_reset) begin
            ul_q <= OCC_UL_IDLE;
        end else if (wr_acc && paddr == OCC_UNLOCK_OFF) begin
            if (pwdata[15:0] == OCC_KEY1) begin
                ul_q <= OCC_UL_KEY1;
            end else if (pwdata[15:0] == OCC_KEY2 && ul_q == OCC_UL_KEY1) begin
                ul_q <= OCC_UL_OPEN;
            end else begin
                ul_q <= OCC_UL_IDLE;
            end
        end else if (wr_acc) begin
            // any other write consumes the unlock
            ul_q <= OCC_UL_IDLE;
        end
    end

    // ************************************************************
    // oscillator_control
    // ************************************************************
    // por_reset loads constants; the strap is caught the cycle after release
    always_ff @(posedge mclk) begin
        if (por_reset) begin
            init_done_q <= 1'b0;
            cur_q <= 3'h0;
            req_q <= 3'h0;
            swreq_q <= 1'b0;
        end else if (!init_done_q) begin
            init_done_q <= 1'b1;
            cur_q <= init_source_cfg;
            req_q <= init_source_cfg;
        end else begin
            if (wr_osc) begin
                req_q <= pwdata[OCC_REQ_LSB +: 3];
            end
            if (swreq_q && switch_done) begin
                cur_q <= req_q;
                swreq_q <= 1'b0;
            end else if (wr_osc && pwdata[OCC_SWREQ_BIT] && sw_allowed) begin
                swreq_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (por_reset) begin
            src_lock_q <= 1'b0;
            pslk_q <= 1'b0;
            sosc_q <= 1'b0;
        end else if (wr_osc) begin
            src_lock_q <= src_lock_q | pwdata[OCC_SRCLK_BIT];
            pslk_q <= pwdata[OCC_PSLK_BIT];
            sosc_q <= pwdata[OCC_SOSC_BIT];
        end
    end

    // clock-fail: set wins over a clearing write
    always_ff @(posedge mclk) begin
        if (por_reset) begin
            cf_q <= 1'b0;
        end else if (clock_fail_event && switching_mode_cfg == OCC_SWM_ALL) begin
            cf_q <= 1'b1;
        end else if (wr_osc && !pwdata[OCC_CF_BIT]) begin
            cf_q <= 1'b0;
        end
    end

    // pll lock status
    always_ff @(posedge mclk) begin
        if (por_reset) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= pll_enabled && (pll_locked || pll_timer_done);
        end
    end

    // ************************************************************
    // clock_divisor
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (por_reset) begin
            roi_q <= 1'b0;
            doze_q <= OCC_DOZE_RST;
            frcdv_q <= OCC_FRCDV_RST;
            post_q <= OCC_POST_RST;
            pre_q <= OCC_PRE_RST;
        end else if (wr_acc && paddr == OCC_CLK_DIV_OFF) begin
            roi_q <= pwdata[OCC_ROI_BIT];
            doze_q <= pwdata[OCC_DOZE_LSB +: 3];
            frcdv_q <= pwdata[OCC_FRCDV_LSB +: 3];
            // reserved code keeps the previous divider
            if (pwdata[OCC_POST_LSB +: 2] != OCC_POST_RSVD) begin
                post_q <= pwdata[OCC_POST_LSB +: 2];
            end
            pre_q <= pwdata[4:0];
        end
    end

    // interrupt recovery beats a write setting doze enable
    always_ff @(posedge mclk) begin
        if (por_reset) begin
            doze_enable_q <= 1'b0;
        end else if (roi_q && interrupt_event) begin
            doze_enable_q <= 1'b0;
        end else if (wr_acc && paddr == OCC_CLK_DIV_OFF) begin
            doze_enable_q <= pwdata[OCC_DOZE_ENABLE_BIT];
        end
    end

    // ************************************************************
    // pll_feedback_divisor and fast_rc_tuning
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (por_reset) begin
            fbd_q <= OCC_FBD_RST;
            trim_q <= OCC_TRIM_RST;
        end else begin
            if (wr_acc && paddr == OCC_PLL_FBD_OFF) begin
                fbd_q <= pwdata[8:0];
            end
            if (wr_acc && paddr == OCC_TUNE_OFF) begin
                trim_q <= pwdata[5:0];
            end
        end
    end

    // ************************************************************
    // decoded control outputs, registered
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset || por_reset) begin
            doze_divide <= 8'h01;
            fast_rc_divide <= 9'h001;
            pll_output_divide <= 4'h4;
            pll_input_divide <= 6'h02;
            pll_multiplier <= 10'h032;
        end else begin
            doze_divide <= doze_enable_q ? (8'h01 << doze_q) : 8'h01;
            fast_rc_divide <= (frcdv_q == 3'h7) ? 9'h100 : (9'h001 << frcdv_q);
            case (post_q)
                2'h0: pll_output_divide <= 4'h2;
                2'h1: pll_output_divide <= 4'h4;
                2'h3: pll_output_divide <= 4'h8;
                default: pll_output_divide <= 4'h4;
            endcase
            pll_input_divide <= {1'b0, pre_q} + 6'h02;
            pll_multiplier <= {1'b0, fbd_q} + 10'h002;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || por_reset) begin
            current_source_sel <= 3'h0;
            requested_source_sel <= 3'h0;
            switch_start <= 1'b0;
            pin_select_lock <= 1'b0;
            secondary_osc_enable <= 1'b0;
            fail_safe_monitor <= 1'b0;
            fast_rc_trim <= 6'h00;
        end else begin
            current_source_sel <= cur_q;
            requested_source_sel <= req_q;
            switch_start <= swreq_q;
            pin_select_lock <= pslk_q;
            secondary_osc_enable <= sosc_q;
            fail_safe_monitor <= switching_mode_cfg == OCC_SWM_ALL;
            fast_rc_trim <= trim_q;
        end
    end

    // ************************************************************
    // apb read path and response
    // ************************************************************
    assign osc_rd = {1'b0, cur_q, 1'b0, req_q, src_lock_q, pslk_q, lock_q, 1'b0,
        cf_q, 1'b0, sosc_q, swreq_q};

    always_comb begin
        rd_d = 32'h0;
        case (paddr)
            OCC_OSC_CTRL_OFF: rd_d = {16'h0, osc_rd};
            OCC_CLK_DIV_OFF: rd_d = {16'h0, roi_q, doze_q, doze_enable_q, frcdv_q, post_q, 1'b0,
                pre_q};
            OCC_PLL_FBD_OFF: rd_d = {23'h0, fbd_q};
            OCC_TUNE_OFF: rd_d = {26'h0, trim_q};
            OCC_UNLOCK_OFF: rd_d = {31'h0, ul_q == OCC_UL_OPEN};
            default: rd_d = 32'h0;
        endcase
    end

    // zero-wait-state slave: pready asserted in the first access cycle
    always_ff @(posedge mclk) begin
        if (reset || por_reset) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && unmapped;
            prdata <= (psel && !penable && !pwrite) ? rd_d : 32'h0;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    switch_blocked_a: assert property (@(posedge mclk) disable iff (por_reset)
        (!sw_allowed && !swreq_q) |=> !swreq_q)
        else $error("switch request set while switching disabled");

    switch_copy_a: assert property (@(posedge mclk) disable iff (por_reset)
        (init_done_q && swreq_q && switch_done) |=> (!swreq_q && cur_q == $past(req_q)))
        else $error("completed switch did not copy source");

    lock_sticky_a: assert property (@(posedge mclk) disable iff (por_reset)
        src_lock_q |=> src_lock_q)
        else $error("clock lock bit cleared by software");

    fail_set_a: assert property (@(posedge mclk) disable iff (por_reset)
        (clock_fail_event && switching_mode_cfg == OCC_SWM_ALL) |=> cf_q)
        else $error("clock fail not flagged");

    fail_noset_a: assert property (@(posedge mclk) disable iff (por_reset)
        (!cf_q && !clock_fail_event) |=> !cf_q)
        else $error("clock fail set by software");

    osc_guard_a: assert property (@(posedge mclk) disable iff (por_reset)
        (init_done_q && ul_q != OCC_UL_OPEN) |=> $stable(req_q))
        else $error("oscillator control written while locked");

    roi_clear_a: assert property (@(posedge mclk) disable iff (por_reset)
        (roi_q && interrupt_event) |=> !doze_enable_q ##1 doze_divide == 8'h01)
        else $error("interrupt recovery did not restore 1:1");

    pll_lock_a: assert property (@(posedge mclk) disable iff (por_reset)
        !pll_enabled |=> !lock_q)
        else $error("pll lock reported while disabled");

    reset_keep_a: assert property (@(posedge mclk) disable iff (por_reset)
        (reset && init_done_q && !wr_acc) |=> $stable(fbd_q) && $stable(trim_q))
        else $error("register changed by non-power-on reset");

    post_div_a: assert property (@(posedge mclk) disable iff (por_reset || reset)
        post_q == 2'h3 |=> pll_output_divide == 4'h8)
        else $error("pll output divider decode wrong");

    fail_clear_a: assert property (@(posedge mclk) disable iff (por_reset)
        (wr_osc && !pwdata[OCC_CF_BIT] && !clock_fail_event) |=> !cf_q)
        else $error("clock fail not cleared by write");

    post_keep_a: assert property (@(posedge mclk) disable iff (por_reset)
        (wr_acc && paddr == OCC_CLK_DIV_OFF && pwdata[7:6] == OCC_POST_RSVD) |=> $stable(post_q))
        else $error("reserved pll output code accepted");

    lock_flag_a: assert property (@(posedge mclk) disable iff (por_reset)
        (pll_enabled && (pll_locked || pll_timer_done)) |=> lock_q)
        else $error("pll lock not reported");

    doze_off_a: assert property (@(posedge mclk) disable iff (por_reset || reset)
        !doze_enable_q |=> doze_divide == 8'h01)
        else $error("doze ratio applied while disabled");

    bad_addr_a: assert property (@(posedge mclk) disable iff (por_reset || reset)
        (psel && !penable && unmapped) |=> (pslverr && prdata == 32'h0))
        else $error("unmapped access not flagged");

    switch_req_a: assert property (@(posedge mclk) disable iff (por_reset)
        (wr_osc && pwdata[OCC_SWREQ_BIT] && sw_allowed && !swreq_q) |=> swreq_q)
        else $error("allowed switch request not taken");

endmodule
